/* File: rtl/rail_b_cfg_pkg.sv */
// Constants for the rail B transient loop configuration bank
`default_nettype none
package rail_b_cfg_pkg;
  localparam int         ADDR_W = 8;
  localparam int         DATA_W = 8;
  localparam int         NUM_REGS = 8;
  localparam logic [7:0] BASE_OFFSET = 8'h6B;
  localparam logic [7:0] OFF_SINGLE_RESP = 8'h6B;
  localparam logic [7:0] OFF_RAMP_EXT = 8'h6C;
  localparam logic [7:0] OFF_RSVD_ONE = 8'h6D;
  localparam logic [7:0] OFF_RSVD_TWO = 8'h6E;
  localparam logic [7:0] OFF_RSVD_THREE = 8'h6F;
  localparam logic [7:0] OFF_OFF_TIME = 8'h70;
  localparam logic [7:0] OFF_GAIN_TEMP = 8'h71;
  localparam logic [7:0] OFF_ABS_TRIG = 8'h72;
  // Values after reset
  localparam logic [7:0] RST_SINGLE_RESP = 8'h00;
  localparam logic [7:0] RST_RAMP_EXT = 8'h00;
  localparam logic [7:0] RST_RSVD_ONE = 8'h0C;
  localparam logic [7:0] RST_RSVD_TWO = 8'h00;
  localparam logic [7:0] RST_RSVD_THREE = 8'h8C;
  localparam logic [7:0] RST_OFF_TIME = 8'h0E;
  localparam logic [7:0] RST_GAIN_TEMP = 8'h00;
  localparam logic [7:0] RST_ABS_TRIG = 8'h00;
  // Field positions
  localparam int FW_LSB = 5;
  localparam int TL_LSB = 0;
  localparam int AR_LSB = 5;
  localparam int EXT_EN_BIT = 4;
  localparam int EXT_TH_LSB = 2;
  localparam int EXT_MAX_LSB = 0;
  localparam int TOFF_LSB = 6;
  localparam int MULTI_SEL_BIT = 5;
  localparam int SINGLE_SEL_BIT = 4;
  localparam int GAIN_BIT = 7;
  localparam int SLL_LSB = 4;
  localparam int TSRC_BIT = 1;
  localparam int TRIG_BIT = 6;
  localparam int OVS_LSB = 3;
  localparam int AQR_LSB = 0;
  // Reserved-bit masks, then field disable codes; reserved bits hold their pattern
  localparam logic [7:0] OFF_TIME_RSVD_MASK = 8'h0F;
  localparam logic [7:0] GAIN_RSVD_MASK = 8'h0D;
  localparam logic [7:0] TRIG_RSVD_MASK = 8'h80;
  localparam logic [4:0] TL_DISABLE = 5'h1F;
  localparam logic [2:0] AR_OFF_A = 3'h3;
  localparam logic [2:0] AR_OFF_B = 3'h7;
  localparam logic [2:0] ABS_OFF = 3'h0;
endpackage
`default_nettype wire

/* File: rtl/cfg_byte_store.sv */
// Byte register store with reset patterns and registered read data
`default_nettype none
module cfg_byte_store #(
  parameter int                     N = 8,
  parameter logic [N*8-1:0]         RST_VALS = '0,
  parameter logic [N*8-1:0]         KEEP_MASK = '0
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Write port
  input  wire logic                 wr_en,
  input  wire logic [$clog2(N)-1:0] wr_idx,
  input  wire logic [7:0]           wr_data,
  // Read port
  input  wire logic [$clog2(N)-1:0] rd_idx,
  output var  logic [7:0]           rd_data_q,
  // All contents
  output var  logic [N*8-1:0]       regs_q
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_reg
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          regs_q[g*8 +: 8] <= RST_VALS[g*8 +: 8];
        end else if (wr_en && wr_idx == g) begin
          // Reserved bits keep their pattern regardless of writes
          regs_q[g*8 +: 8] <= (wr_data & ~KEEP_MASK[g*8 +: 8])
                            | (RST_VALS[g*8 +: 8] & KEEP_MASK[g*8 +: 8]);
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= regs_q[rd_idx*8 +: 8];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rail_b_transient_loop_config.sv */
// Rail B transient loop configuration register bank, offsets 6B..72
// How it works
// - Fixed response width code, 0.50 to 2.25 ton
// - Trigger level 40mV steps; all ones disables
// - Ramp threshold decode; 011 and 111 disable
// - Bit four enables on-time extension
// - Extension threshold 150 to 300 mV
// - Max extended on-time 1.625 down to 1.250
// - Reserved slots default 0C, 00, 8C
// - Minimum off-time 300, 200, 120, 50 ns
// - Multi-phase response type: fixed or adaptive
// - Single-phase response type: fixed or adaptive
// - Off-time reserved low nibble stays 1110
// - Gain bit selects 2/3 or 1
// - Short-term load-line ratio 100 to 50 percent
// - Temperature source: thermistor or power stage
// - Gain and trigger reserved bits stay zero
// - Trigger mechanism absolute or differential
// - Overshoot threshold 20-50mV, zero disables
// - Response threshold 20-50mV, zero disables
`default_nettype none
module rail_b_transient_loop_config
  import rail_b_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // Register access from the serial interface
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [rail_b_cfg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [rail_b_cfg_pkg::DATA_W-1:0] reg_wdata,
  output var  logic [rail_b_cfg_pkg::DATA_W-1:0] reg_rdata_q,
  output var  logic                          reg_rvalid_q,
  output var  logic                          reg_hit_q,
  // Decoded fields to the control loop
  output var  logic [2:0]                    single_fixed_response_width_q,
  output var  logic [4:0]                    single_response_trigger_level_q,
  output var  logic                          single_trigger_disable_q,
  output var  logic [2:0]                    single_adaptive_ramp_threshold_q,
  output var  logic                          adaptive_ramp_disable_q,
  output var  logic                          on_time_extension_enable_q,
  output var  logic [1:0]                    on_time_extension_threshold_q,
  output var  logic [1:0]                    max_extended_on_time_q,
  output var  logic [1:0]                    minimum_off_time_q,
  output var  logic                          multi_response_type_select_q,
  output var  logic                          single_response_type_select_q,
  output var  logic                          error_amp_transconductance_q,
  output var  logic [2:0]                    short_term_loadline_ratio_q,
  output var  logic                          temperature_source_select_q,
  output var  logic                          response_trigger_mechanism_q,
  output var  logic [2:0]                    absolute_overshoot_threshold_q,
  output var  logic                          overshoot_disable_q,
  output var  logic [2:0]                    absolute_response_threshold_q,
  output var  logic                          absolute_response_disable_q
);
  import rail_b_cfg_pkg::*;

  localparam int IDX_W = $clog2(NUM_REGS);
  localparam logic [NUM_REGS*8-1:0] RST_VALS = {
    RST_ABS_TRIG, RST_GAIN_TEMP, RST_OFF_TIME, RST_RSVD_THREE,
    RST_RSVD_TWO, RST_RSVD_ONE, RST_RAMP_EXT, RST_SINGLE_RESP};
  // Whole reserved slots and reserved bits are not writable
  localparam logic [NUM_REGS*8-1:0] KEEP = {
    TRIG_RSVD_MASK, GAIN_RSVD_MASK, OFF_TIME_RSVD_MASK, 8'hFF,
    8'hFF, 8'hFF, 8'h00, 8'h00};

  logic             in_range;
  logic [7:0]       rel_addr;
  logic [IDX_W-1:0] idx;
  logic [7:0]       store_rd;
  logic [NUM_REGS*8-1:0] regs;
  logic             rd_pend_q;
  logic             rd_hit_q;
  logic [7:0]       r6b, r6c, r70, r71, r72;

  assign rel_addr = reg_addr - BASE_OFFSET;
  assign in_range = (reg_addr >= OFF_SINGLE_RESP)
                 && (reg_addr <= OFF_ABS_TRIG);
  assign idx = rel_addr[IDX_W-1:0];

  // Reserved slots ignore writes so an undefined value never lands
  cfg_byte_store #(
    .N         (NUM_REGS),
    .RST_VALS  (RST_VALS),
    .KEEP_MASK (KEEP)
  ) u_store (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .wr_en     (reg_wr && in_range),
    .wr_idx    (idx),
    .wr_data   (reg_wdata),
    .rd_idx    (idx),
    .rd_data_q (store_rd),
    .regs_q    (regs)
  );

  assign r6b = regs[0*8 +: 8];
  assign r6c = regs[1*8 +: 8];
  assign r70 = regs[5*8 +: 8];
  assign r71 = regs[6*8 +: 8];
  assign r72 = regs[7*8 +: 8];

  // Read answer one cycle after store capture; unmapped reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      rd_hit_q  <= 1'b0;
    end else begin
      rd_pend_q <= reg_rd;
      rd_hit_q  <= reg_rd && in_range;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
      reg_hit_q    <= 1'b0;
    end else begin
      reg_rvalid_q <= rd_pend_q;
      reg_hit_q    <= rd_hit_q;
      reg_rdata_q  <= rd_hit_q ? store_rd : 8'h00;
    end
  end

  // Single-phase response fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      single_fixed_response_width_q    <= 3'h0;
      single_response_trigger_level_q  <= 5'h00;
      single_trigger_disable_q         <= 1'b0;
      single_adaptive_ramp_threshold_q <= 3'h0;
      adaptive_ramp_disable_q          <= 1'b0;
      on_time_extension_enable_q       <= 1'b0;
      on_time_extension_threshold_q    <= 2'h0;
      max_extended_on_time_q           <= 2'h0;
    end else begin
      single_fixed_response_width_q    <= r6b[FW_LSB +: 3];
      single_response_trigger_level_q  <= r6b[TL_LSB +: 5];
      single_trigger_disable_q <= r6b[TL_LSB +: 5] == TL_DISABLE;
      single_adaptive_ramp_threshold_q <= r6c[AR_LSB +: 3];
      adaptive_ramp_disable_q <= r6c[AR_LSB +: 3] == AR_OFF_A
                              || r6c[AR_LSB +: 3] == AR_OFF_B;
      on_time_extension_enable_q       <= r6c[EXT_EN_BIT];
      on_time_extension_threshold_q    <= r6c[EXT_TH_LSB +: 2];
      max_extended_on_time_q           <= r6c[EXT_MAX_LSB +: 2];
    end
  end

  // Off-time, gain, temperature and absolute trigger fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      minimum_off_time_q             <= 2'h0;
      multi_response_type_select_q   <= 1'b0;
      single_response_type_select_q  <= 1'b0;
      error_amp_transconductance_q   <= 1'b0;
      short_term_loadline_ratio_q    <= 3'h0;
      temperature_source_select_q    <= 1'b0;
      response_trigger_mechanism_q   <= 1'b0;
      absolute_overshoot_threshold_q <= 3'h0;
      overshoot_disable_q            <= 1'b1;
      absolute_response_threshold_q  <= 3'h0;
      absolute_response_disable_q    <= 1'b1;
    end else begin
      minimum_off_time_q            <= r70[TOFF_LSB +: 2];
      multi_response_type_select_q  <= r70[MULTI_SEL_BIT];
      single_response_type_select_q <= r70[SINGLE_SEL_BIT];
      error_amp_transconductance_q  <= r71[GAIN_BIT];
      short_term_loadline_ratio_q   <= r71[SLL_LSB +: 3];
      temperature_source_select_q   <= r71[TSRC_BIT];
      response_trigger_mechanism_q  <= r72[TRIG_BIT];
      absolute_overshoot_threshold_q <= r72[OVS_LSB +: 3];
      overshoot_disable_q <= r72[OVS_LSB +: 3] == ABS_OFF;
      absolute_response_threshold_q <= r72[AQR_LSB +: 3];
      absolute_response_disable_q <= r72[AQR_LSB +: 3] == ABS_OFF;
    end
  end

  // Checks
  property p_rsvd_slots;
    @(posedge ref_clk) disable iff (rst)
    regs[2*8 +: 24] == {RST_RSVD_THREE, RST_RSVD_TWO, RST_RSVD_ONE};
  endproperty
  a_rsvd_slots: assert property (p_rsvd_slots)
    else $error("reserved slot changed");

  property p_off_nibble;
    @(posedge ref_clk) disable iff (rst)
    (r70 & OFF_TIME_RSVD_MASK) == RST_OFF_TIME;
  endproperty
  a_off_nibble: assert property (p_off_nibble)
    else $error("off-time reserved nibble changed");

  property p_zero_rsvd;
    @(posedge ref_clk) disable iff (rst)
    (r71 & GAIN_RSVD_MASK) == 8'h00 && r72[7] == 1'b0;
  endproperty
  a_zero_rsvd: assert property (p_zero_rsvd)
    else $error("zero reserved bits set");

  property p_readback;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_SINGLE_RESP ##1 reg_rd
      && reg_addr == OFF_SINGLE_RESP && !reg_wr)
      |-> ##2 reg_rvalid_q && reg_rdata_q == $past(reg_wdata, 3);
  endproperty
  a_readback: assert property (p_readback)
    else $error("read did not return written value");

  property p_unmapped;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && !in_range) |-> ##2 reg_rvalid_q && !reg_hit_q
      && reg_rdata_q == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_trig_dis;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_SINGLE_RESP && reg_wdata[4:0] == TL_DISABLE)
      |-> ##2 single_trigger_disable_q;
  endproperty
  a_trig_dis: assert property (p_trig_dis)
    else $error("trigger disable not decoded");

  property p_ramp_dis;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_RAMP_EXT)
      |-> ##2 adaptive_ramp_disable_q
      == ($past(reg_wdata[7:5], 2) == AR_OFF_A
      || $past(reg_wdata[7:5], 2) == AR_OFF_B)
      && single_adaptive_ramp_threshold_q == $past(reg_wdata[7:5], 2);
  endproperty
  a_ramp_dis: assert property (p_ramp_dis)
    else $error("ramp disable not decoded");

  property p_ext_en;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_RAMP_EXT)
      |-> ##2 on_time_extension_enable_q == $past(reg_wdata[4], 2);
  endproperty
  a_ext_en: assert property (p_ext_en)
    else $error("extension enable mismatch");

  property p_abs_dis;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_ABS_TRIG)
      |-> ##2 absolute_response_disable_q == ($past(reg_wdata[2:0], 2)
      == ABS_OFF) && overshoot_disable_q == ($past(reg_wdata[5:3], 2)
      == ABS_OFF);
  endproperty
  a_abs_dis: assert property (p_abs_dis)
    else $error("absolute disable mismatch");

  property p_single_fields;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_SINGLE_RESP)
      |-> ##2 single_fixed_response_width_q == $past(reg_wdata[7:5], 2)
      && single_response_trigger_level_q == $past(reg_wdata[4:0], 2);
  endproperty
  a_single_fields: assert property (p_single_fields)
    else $error("single-phase fields mismatch");

  property p_ext_fields;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_RAMP_EXT)
      |-> ##2 on_time_extension_threshold_q == $past(reg_wdata[3:2], 2)
      && max_extended_on_time_q == $past(reg_wdata[1:0], 2);
  endproperty
  a_ext_fields: assert property (p_ext_fields)
    else $error("extension fields mismatch");

  property p_off_time;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_OFF_TIME)
      |-> ##2 {minimum_off_time_q, multi_response_type_select_q,
      single_response_type_select_q} == $past(reg_wdata[7:4], 2);
  endproperty
  a_off_time: assert property (p_off_time)
    else $error("off-time fields mismatch");

  property p_gain_temp;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_GAIN_TEMP)
      |-> ##2 {error_amp_transconductance_q, short_term_loadline_ratio_q}
      == $past(reg_wdata[7:4], 2)
      && temperature_source_select_q == $past(reg_wdata[1], 2);
  endproperty
  a_gain_temp: assert property (p_gain_temp)
    else $error("gain and temperature fields mismatch");

  property p_trig_mech;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_ABS_TRIG)
      |-> ##2 response_trigger_mechanism_q == $past(reg_wdata[6], 2);
  endproperty
  a_trig_mech: assert property (p_trig_mech)
    else $error("trigger mechanism mismatch");

  // Neighbouring addresses must never alias onto a slot
  property p_unmapped_wr;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && !in_range) |=> $stable(regs);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr)
    else $error("unmapped write changed a register");

  c_write_gain: cover property (@(posedge ref_clk)
    reg_wr && reg_addr == OFF_GAIN_TEMP);
  c_read_hit: cover property (@(posedge ref_clk) reg_rvalid_q && reg_hit_q);
  c_rsvd_write: cover property (@(posedge ref_clk)
    reg_wr && reg_addr == OFF_RSVD_THREE);
endmodule
`default_nettype wire

/* File: testbench/rail_b_host_model.sv */
// Host model issuing register writes and reads to the rail B bank
`default_nettype none
module rail_b_host_model
  import rail_b_cfg_pkg::*;
(
  // Clock
  input  wire logic                              ref_clk,
  // Requests
  output var  logic                              reg_wr,
  output var  logic                              reg_rd,
  output var  logic [rail_b_cfg_pkg::ADDR_W-1:0] reg_addr,
  output var  logic [rail_b_cfg_pkg::DATA_W-1:0] reg_wdata,
  // Answers
  input  wire logic [rail_b_cfg_pkg::DATA_W-1:0] reg_rdata_q,
  input  wire logic                              reg_rvalid_q,
  input  wire logic                              reg_hit_q
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic write_raw(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Well-behaved host keeps every reserved pattern intact
  task automatic write_keep(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = d;
    if (a == 8'h70) m = {d[7:4], 4'hE};
    if (a == 8'h71) m = d & 8'hF2;
    if (a == 8'h72) m = d & 8'h7F;
    if (a < 8'h6D || a > 8'h6F) write_raw(a, m);
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic hit, output int lat);
    @(negedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(negedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    d = 8'hXX;
    hit = 1'bx;
    lat = 0;
    for (int i = 1; i < 6 && lat == 0; i++) begin
      @(posedge ref_clk);
      #1;
      if (reg_rvalid_q === 1'b1) begin
        d = reg_rdata_q;
        hit = reg_hit_q;
        lat = i + 1;
      end
    end
  endtask

  // Write then read the same byte on the very next edge
  task automatic write_read(input logic [7:0] a, input logic [7:0] d,
                            output logic [7:0] q);
    @(negedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_wdata <= ~d;
    @(negedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    #1;
    q = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hXX;
  endtask
endmodule
`default_nettype wire

/* File: testbench/rail_b_transient_loop_config_test.sv */
// Self-checking bench for the rail B configuration bank
`default_nettype none
module rail_b_transient_loop_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid_q, reg_hit_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [2:0] single_fixed_response_width_q, short_term_loadline_ratio_q;
  logic [4:0] single_response_trigger_level_q;
  logic [2:0] single_adaptive_ramp_threshold_q;
  logic [2:0] absolute_overshoot_threshold_q, absolute_response_threshold_q;
  logic [1:0] on_time_extension_threshold_q, max_extended_on_time_q;
  logic [1:0] minimum_off_time_q;
  logic single_trigger_disable_q, adaptive_ramp_disable_q;
  logic on_time_extension_enable_q, multi_response_type_select_q;
  logic single_response_type_select_q, error_amp_transconductance_q;
  logic temperature_source_select_q, response_trigger_mechanism_q;
  logic overshoot_disable_q, absolute_response_disable_q;
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h655B;
  logic [7:0] shadow [8];

  rail_b_transient_loop_config dut (
    .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .reg_hit_q(reg_hit_q),
    .single_fixed_response_width_q(single_fixed_response_width_q),
    .single_response_trigger_level_q(single_response_trigger_level_q),
    .single_trigger_disable_q(single_trigger_disable_q),
    .single_adaptive_ramp_threshold_q(single_adaptive_ramp_threshold_q),
    .adaptive_ramp_disable_q(adaptive_ramp_disable_q),
    .on_time_extension_enable_q(on_time_extension_enable_q),
    .on_time_extension_threshold_q(on_time_extension_threshold_q),
    .max_extended_on_time_q(max_extended_on_time_q),
    .minimum_off_time_q(minimum_off_time_q),
    .multi_response_type_select_q(multi_response_type_select_q),
    .single_response_type_select_q(single_response_type_select_q),
    .error_amp_transconductance_q(error_amp_transconductance_q),
    .short_term_loadline_ratio_q(short_term_loadline_ratio_q),
    .temperature_source_select_q(temperature_source_select_q),
    .response_trigger_mechanism_q(response_trigger_mechanism_q),
    .absolute_overshoot_threshold_q(absolute_overshoot_threshold_q),
    .overshoot_disable_q(overshoot_disable_q),
    .absolute_response_threshold_q(absolute_response_threshold_q),
    .absolute_response_disable_q(absolute_response_disable_q)
  );
  rail_b_host_model host (
    .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .reg_hit_q(reg_hit_q)
  );

  always #20 ref_clk = ~ref_clk;

  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Value the bank should hold after a raw write
  function automatic logic [7:0] exp_val(int i, logic [7:0] d, logic [7:0] o);
    case (i)
      2, 3, 4: return o;
      5: return {d[7:4], 4'hE};
      6: return d & 8'hF2;
      7: return d & 8'h7F;
      default: return d;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_fields();
    check(single_fixed_response_width_q, shadow[0][7:5]);
    check(single_response_trigger_level_q, shadow[0][4:0]);
    check(single_trigger_disable_q, shadow[0][4:0] == 5'h1F);
    check(single_adaptive_ramp_threshold_q, shadow[1][7:5]);
    check(adaptive_ramp_disable_q, shadow[1][6:5] == 2'b11);
    check(on_time_extension_enable_q, shadow[1][4]);
    check(on_time_extension_threshold_q, shadow[1][3:2]);
    check(max_extended_on_time_q, shadow[1][1:0]);
    check(minimum_off_time_q, shadow[5][7:6]);
    check(multi_response_type_select_q, shadow[5][5]);
    check(single_response_type_select_q, shadow[5][4]);
    check(error_amp_transconductance_q, shadow[6][7]);
    check(short_term_loadline_ratio_q, shadow[6][6:4]);
    check(temperature_source_select_q, shadow[6][1]);
    check(response_trigger_mechanism_q, shadow[7][6]);
    check(absolute_overshoot_threshold_q, shadow[7][5:3]);
    check(overshoot_disable_q, shadow[7][5:3] == 3'h0);
    check(absolute_response_threshold_q, shadow[7][2:0]);
    check(absolute_response_disable_q, shadow[7][2:0] == 3'h0);
  endtask

  // Write, read back, then compare every decoded field
  task automatic do_op(input int i, input logic [7:0] d, input logic raw);
    logic [7:0] got;
    logic hit;
    int lat;
    if (raw) host.write_raw(8'h6B + 8'(i), d);
    else host.write_keep(8'h6B + 8'(i), d);
    shadow[i] = exp_val(i, d, shadow[i]);
    host.read(8'h6B + 8'(i), got, hit, lat);
    check(got, shadow[i]);
    check(hit, 1'b1);
    check(8'(lat), 8'h02);
    check_fields();
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    results();
  end

  initial begin
    logic [7:0] got;
    logic hit;
    int lat;
    logic [31:0] r;
    shadow = '{8'h00, 8'h00, 8'h0C, 8'h00, 8'h8C, 8'h0E, 8'h00, 8'h00};
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      host.read(8'h6B + 8'(i), got, hit, lat);
      check(got, shadow[i]);
    end
    check_fields();
    host.read(8'h40, got, hit, lat);
    check(hit, 1'b0);
    check(got, 8'h00);
    // Raw writes of all ones hit every reserved place
    for (int i = 0; i < 8; i++) do_op(i, 8'hFF, 1'b1);
    do_op(1, 8'h60, 1'b1);
    do_op(1, 8'h40, 1'b1);
    do_op(0, 8'h1E, 1'b1);
    do_op(7, 8'h00, 1'b1);
    // Write then read on the next edge must see the new byte
    r = next_rand();
    host.write_read(8'h6B, r[7:0], got);
    shadow[0] = r[7:0];
    check(got, r[7:0]);
    check_fields();
    for (int n = 0; n < 200; n++) begin
      r = next_rand();
      do_op(int'(r[2:0]), r[15:8], r[16]);
    end
    // Neighbours of the bank must not alias onto it
    host.write_raw(8'h6A, 8'hA5);
    host.write_raw(8'h73, 8'h5A);
    for (int i = 0; i < 8; i++) begin
      host.read(8'h6B + 8'(i), got, hit, lat);
      check(got, shadow[i]);
    end
    results();
  end
endmodule
`default_nettype wire
